// File: rtl/nbw_write_target.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1 - Start nibble 1110 under low frame strobe opens a write cycle.
// RULE2 - Only the last start nibble before the strobe rises counts.
// RULE3 - Select nibble must equal the identity straps to take part.
// RULE4 - Seven address nibbles, most significant first, form 28 bits.
// RULE5 - Size nibble 0000 means one byte; only single-byte writes.
// RULE6 - Low data nibble in cycle 11, high in cycle 12.
// RULE7 - Host turns around in 13; device takes bus in 14.
// RULE8 - Device drives ready sync 0000 in cycle 15.
// RULE9 - Device drives 1111 in 16 then floats; host resumes in 17.
// RULE10 - Nibbles are sampled on the rising clock edge.
// RULE11 - No explicit error indication for bad fields.
// RULE12 - Decode 20 address bits; 4-Mbit also drops bit 19.
// RULE13 - Respond regardless of undecoded upper address bits.
// RULE14 - Address bit 22 picks flash array or register space.
// RULE15 - Bad size nibble resets the machine, no operation, no response.
// RULE16 - After valid start, select and size, later inputs are trusted.
// RULE17 - Command bytes are accepted without validity checks.
// RULE18 - Low frame strobe floats the bus and resets the machine.
// RULE19 - Abort does not stop a launched program or erase.
// RULE20 - Host stops program or erase with a command, not the strobe.
// RULE21 - No flash operation launched before the last data nibble.
// RULE22 - Host holds reset 1 ms after power, 100 us after clock; the testbench holds it for 5 clock cycles.
// RULE23 - Mismatch or unknown start keeps device off bus till next strobe.
module nbw_write_target (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic frame_strobe_n_in,
  input wire logic [3:0] nibble_bus_in,
  output logic [3:0] nibble_bus_out,
  output logic nibble_bus_oe_out,
  input wire logic [3:0] strap_identity_pins_in,
  input wire logic density_8m_in,
  output logic write_valid_out,
  output logic write_region_flash_out,
  output logic [19:0] write_offset_out,
  output logic [7:0] write_byte_out
);
  import nbw_pkg::*;
  nbw_field_if fld ();
  nbw_state_e state_r;
  nbw_state_e state_nxt;
  logic [2:0] index_r;
  logic [2:0] index_nxt;
  logic [3:0] data_lo_r;
  logic [3:0] bus_out_nxt;
  logic oe_nxt;
  logic strobe_low;
  logic start_is_write;
  logic id_match;
  logic size_ok;
  logic launch;
  logic density_r;

  nbw_addr_asm u_asm (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .fld(fld)
  );

  assign strobe_low = ~frame_strobe_n_in;
  assign start_is_write = (nibble_bus_in == NBW_START_WRITE); // RULE1
  assign id_match = (nibble_bus_in == strap_identity_pins_in); // RULE3
  assign size_ok = (nibble_bus_in == NBW_SIZE_ONE); // RULE5
  // Launch only on the high data nibble, so an abort up to it is harmless
  assign launch = (state_r == NBW_DATA_HI) && !strobe_low; // RULE21
  assign fld.nibble = nibble_bus_in; // RULE10
  assign fld.load = (state_r == NBW_ADDR) && !strobe_low;
  assign fld.index = index_r;
  assign fld.density_8m = density_r;

  always_comb begin
    state_nxt = state_r;
    index_nxt = index_r;
    if (strobe_low) begin
      // Each low-strobe cycle restarts; last start seen wins
      state_nxt = start_is_write ? NBW_SELECT : NBW_IGNORE; // RULE2 RULE18
      index_nxt = 3'h0;
    end else begin
      case (state_r)
        NBW_IDLE: state_nxt = NBW_IDLE;
        NBW_SELECT: begin
          state_nxt = id_match ? NBW_ADDR : NBW_IGNORE; // RULE23
        end
        NBW_ADDR: begin
          index_nxt = 3'(index_r + 3'h1);
          if (index_r == NBW_ADDR_LAST) begin
            state_nxt = NBW_SIZE;
          end
        end
        NBW_SIZE: begin
          // Silent reset on bad size, nothing driven
          state_nxt = size_ok ? NBW_DATA_LO : NBW_IDLE; // RULE15 RULE11
        end
        NBW_DATA_LO: state_nxt = NBW_DATA_HI; // RULE6
        NBW_DATA_HI: state_nxt = NBW_TURNAROUND_FIRST; // RULE16 RULE17
        NBW_TURNAROUND_FIRST: state_nxt = NBW_TURNAROUND_SECOND; // RULE7
        NBW_TURNAROUND_SECOND: state_nxt = NBW_SYNC;
        NBW_SYNC: state_nxt = NBW_OTAR0; // RULE8
        NBW_OTAR0: state_nxt = NBW_IDLE; // RULE9
        NBW_IGNORE: state_nxt = NBW_IGNORE; // RULE23
        default: state_nxt = NBW_IDLE;
      endcase
    end
  end

  // Drive decisions registered: bus value for the following cycle
  assign oe_nxt = !strobe_low && ((state_r == NBW_TURNAROUND_FIRST) ||
    (state_r == NBW_TURNAROUND_SECOND) || (state_r == NBW_SYNC)); // RULE7 RULE9
  assign bus_out_nxt = (state_r == NBW_TURNAROUND_SECOND) ? NBW_SYNC_READY :
    NBW_TAR_VALUE; // RULE8

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= NBW_IDLE;
      index_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      index_r <= index_nxt;
    end
  end

  // Strap captured on edges while reset is held, then frozen
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      density_r <= density_8m_in;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      data_lo_r <= 4'h0;
    end else if (state_r == NBW_DATA_LO && !strobe_low) begin
      data_lo_r <= nibble_bus_in; // RULE6
    end
  end

  // Outputs float on the first edge that samples the strobe low; oe_nxt is combinational
  // in strobe, so the registered drive stops on that next edge, not before
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      nibble_bus_out <= 4'hF;
      nibble_bus_oe_out <= 1'b0;
    end else begin
      nibble_bus_out <= bus_out_nxt;
      nibble_bus_oe_out <= oe_nxt; // RULE18
    end
  end

  // Write pulse is not withdrawn by a later abort
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      write_valid_out <= 1'b0;
      write_byte_out <= 8'h00;
      write_offset_out <= 20'h00000;
      write_region_flash_out <= 1'b0;
    end else begin
      write_valid_out <= launch; // RULE19 RULE21
      if (launch) begin
        write_byte_out <= {nibble_bus_in, data_lo_r}; // RULE6 RULE17
        write_offset_out <= fld.offset; // RULE12 RULE13
        write_region_flash_out <= fld.region_flash; // RULE14
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/nbw_pkg.sv
package nbw_pkg;
  localparam logic [3:0] NBW_START_WRITE = 4'hE;
  localparam logic [3:0] NBW_START_READ = 4'hD;
  localparam logic [3:0] NBW_SIZE_ONE = 4'h0;
  localparam logic [3:0] NBW_SYNC_READY = 4'h0;
  localparam logic [3:0] NBW_TAR_VALUE = 4'hF;
  localparam int NBW_ADDR_NIBBLES = 7;
  localparam int NBW_ADDR_W = 28;
  localparam int NBW_DEC_W = 20;
  localparam int NBW_REGION_BIT = 22;
  localparam int NBW_HALF_BIT = 19;
  localparam logic [2:0] NBW_ADDR_LAST = 3'h6;
  localparam logic NBW_DENSITY_8M = 1'b1;
  localparam int NBW_RESET_POWER_MS = 1;
  localparam int NBW_RESET_CLOCK_US = 100;
  localparam int NBW_CLOCK_HZ = 10000000;
  localparam int NBW_RESET_CLOCK_CYCLES =
    (NBW_RESET_CLOCK_US * (NBW_CLOCK_HZ / 1000000));
  typedef enum logic [3:0] {
    NBW_IDLE, NBW_SELECT, NBW_ADDR, NBW_SIZE, NBW_DATA_LO, NBW_DATA_HI,
    NBW_TURNAROUND_FIRST, NBW_TURNAROUND_SECOND, NBW_SYNC, NBW_OTAR0, NBW_IGNORE
  } nbw_state_e;
endpackage

// File: rtl/nbw_field_if.sv
`timescale 1ns/1ps
`default_nettype none
interface nbw_field_if;
  logic [3:0] nibble;
  logic load;
  logic [2:0] index;
  logic density_8m;
  logic [19:0] offset;
  logic region_flash;
  modport fsm (output nibble, output load, output index, output density_8m,
    input offset, input region_flash);
  modport asm (input nibble, input load, input index, input density_8m,
    output offset, output region_flash);
endinterface
`default_nettype wire

// File: rtl/nbw_addr_asm.sv
`timescale 1ns/1ps
`default_nettype none
module nbw_addr_asm (
  input wire logic clock_in,
  input wire logic rst_in,
  nbw_field_if.asm fld
);
  import nbw_pkg::*;
  logic [NBW_ADDR_W-1:0] addr_r;
  logic [NBW_ADDR_W-1:0] addr_nxt;
  logic [NBW_DEC_W-1:0] dec_mask;
  // Shift in MSB first
  assign addr_nxt = fld.load ? {addr_r[NBW_ADDR_W-5:0], fld.nibble}
                             : addr_r; // RULE4
  // Upper bits are simply dropped, so any value aliases down
  assign dec_mask = fld.density_8m ? 20'hFFFFF : 20'h7FFFF; // RULE12
  assign fld.offset = addr_r[NBW_DEC_W-1:0] & dec_mask; // RULE13
  assign fld.region_flash = addr_r[NBW_REGION_BIT]; // RULE14
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      addr_r <= 28'h0000000;
    end else begin
      addr_r <= addr_nxt;
    end
  end
endmodule
`default_nettype wire

// File: tb/nbw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module nbw_host_model (
  input wire logic clock_in,
  input wire logic oe_in,
  input wire logic [3:0] dev_in,
  output logic strobe_n_out,
  output logic [3:0] bus_out
);
  logic [3:0] hv = 4'hF;
  logic he = 1'b1;
  logic [3:0] last = 4'hF;
  initial strobe_n_out = 1'b1;
  // Released bus shows inverse of last value, no pull-up assumed
  assign bus_out = oe_in ? dev_in : (he ? hv : ~last);
  always @(posedge clock_in) last <= bus_out;
  task automatic frame(input logic [3:0] st, input logic [3:0] sel,
    input logic [27:0] a, input logic [3:0] sz, input logic [7:0] d,
    input int cut, input int two);
    logic [51:0] v;
    v = {st, sel, a, sz, d[3:0], d[7:4], 4'hF};
    if (two != 0) begin
      @(posedge clock_in);
      strobe_n_out <= 1'b0;
      hv <= 4'hD;
    end
    for (int i = 0; i < 13; i++) begin
      @(posedge clock_in);
      strobe_n_out <= !(i == 0 || i == cut);
      hv <= v[51 - 4 * i -: 4];
      he <= 1'b1;
    end
    @(posedge clock_in);
    he <= 1'b0;
    strobe_n_out <= 1'b1;
    repeat (3) @(posedge clock_in);
    he <= 1'b1;
    hv <= 4'hF;
  endtask
endmodule
`default_nettype wire

// File: tb/nbw_write_target_chk.sv
`timescale 1ns/1ps
`default_nettype none
module nbw_write_target_chk (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic frame_strobe_n_in,
  input wire logic [3:0] nibble_bus_in,
  input wire logic [3:0] nibble_bus_out,
  input wire logic nibble_bus_oe_out,
  input wire logic [3:0] strap_identity_pins_in,
  input wire logic density_8m_in,
  input wire logic write_valid_out,
  input wire logic write_region_flash_out,
  input wire logic [19:0] write_offset_out,
  input wire logic [7:0] write_byte_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sync_seq_a: assert property (
    write_valid_out && frame_strobe_n_in ##1 frame_strobe_n_in ##1
    frame_strobe_n_in |->
    $past(nibble_bus_oe_out) && $past(nibble_bus_out) == 4'hF &&
    nibble_bus_oe_out && nibble_bus_out == 4'h0 ##1
    nibble_bus_oe_out && nibble_bus_out == 4'hF ##1 !nibble_bus_oe_out)
    else $error("sync sequence wrong");
  strobe_float_a: assert property (!frame_strobe_n_in |=>
    !nibble_bus_oe_out) else $error("bus driven after strobe low");
  valid_pulse_a: assert property (write_valid_out |=>
    !write_valid_out) else $error("write pulse too long");
  oe_cause_a: assert property ($rose(nibble_bus_oe_out) |->
    $past(write_valid_out)) else $error("bus driven without write");
  start_frame_a: assert property (write_valid_out |->
    $past(nibble_bus_in, 12) == 4'hE && !$past(frame_strobe_n_in, 12) &&
    $past(frame_strobe_n_in, 11) && $past(frame_strobe_n_in))
    else $error("write without proper start");
  select_match_a: assert property (write_valid_out |->
    $past(nibble_bus_in, 11) == strap_identity_pins_in)
    else $error("write on wrong select");
  size_one_a: assert property (write_valid_out |->
    $past(nibble_bus_in, 3) == 4'h0) else $error("write on bad size");
  data_byte_a: assert property (write_valid_out |->
    write_byte_out == {$past(nibble_bus_in), $past(nibble_bus_in, 2)})
    else $error("data byte wrong");
  region_bit_a: assert property (write_valid_out |->
    write_region_flash_out == $past(nibble_bus_in[2], 9))
    else $error("region bit wrong");
  offset_dec_a: assert property (write_valid_out |->
    write_offset_out == {$past(nibble_bus_in, 8) & {density_8m_in, 3'h7},
    $past(nibble_bus_in, 7), $past(nibble_bus_in, 6),
    $past(nibble_bus_in, 5), $past(nibble_bus_in, 4)})
    else $error("offset wrong");
endmodule
bind nbw_write_target nbw_write_target_chk u_chk (.*);
`default_nettype wire

// File: tb/test_nbw_write_target.sv
`timescale 1ns/1ps
`default_nettype none
module test_nbw_write_target;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic dens = 1'b1;
  logic [3:0] straps = 4'h5;
  wire logic [3:0] bus, dout;
  wire logic fs, oe, wv, rf;
  wire logic [19:0] off;
  wire logic [7:0] wb;
  int errors = 0, samples_checked = 0, nv = 0, cyc = 0;
  initial forever #50 clock_in = ~clock_in;
  nbw_host_model u_host (.clock_in(clock_in), .oe_in(oe), .dev_in(dout),
    .strobe_n_out(fs), .bus_out(bus));
  nbw_write_target u_dut (.clock_in(clock_in), .rst_in(rst_in),
    .frame_strobe_n_in(fs), .nibble_bus_in(bus), .nibble_bus_out(dout),
    .nibble_bus_oe_out(oe), .strap_identity_pins_in(straps),
    .density_8m_in(dens), .write_valid_out(wv),
    .write_region_flash_out(rf), .write_offset_out(off),
    .write_byte_out(wb));
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clock_in) begin
    cyc++;
    if (wv === 1'b1) nv++;
    if (cyc == 4000) begin
      errors++;
      results();
    end
  end
  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic reset_to(input logic d);
    rst_in <= 1'b1;
    dens <= d;
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic go(input logic [3:0] st, input logic [3:0] sel,
    input logic [27:0] a, input logic [3:0] sz, input int cut,
    input int two, input int exp_n);
    int n0;
    n0 = nv;
    u_host.frame(st, sel, a, sz, a[7:0] ^ 8'h3C, cut, two);
    check(28'(nv - n0), 28'(exp_n));
  endtask
  task automatic t_write;
    logic [27:0] al [2] = '{28'h9471234, 28'h0B85678};
    foreach (al[i]) begin
      go(4'hE, 4'h5, al[i], 4'h0, -1, 0, 1);
      check(28'(wb), 28'(al[i][7:0] ^ 8'h3C));
      check(28'(rf), 28'(al[i][22]));
      check(28'(off), 28'(al[i][19:0]));
    end
    $display("write test done");
  endtask
  task automatic t_refuse;
    go(4'hE, 4'h6, 28'h0400000, 4'h0, -1, 0, 0);
    go(4'hE, 4'h5, 28'h0400000, 4'h1, -1, 0, 0);
    go(4'hE, 4'h5, 28'h0400000, 4'hF, -1, 0, 0);
    go(4'hD, 4'h5, 28'h0400000, 4'h0, -1, 0, 0);
    go(4'hE, 4'h5, 28'h0400000, 4'h0, 11, 0, 0);
    go(4'hE, 4'h5, 28'h0400000, 4'h0, 2, 0, 0);
    go(4'hE, 4'h5, 28'h0400000, 4'h0, 12, 0, 1);
    go(4'hE, 4'h5, 28'h0400000, 4'h0, -1, 1, 1);
    $display("refusal test done");
  endtask
  task automatic t_density;
    reset_to(1'b0);
    go(4'hE, 4'h5, 28'hF4ABCDE, 4'h0, -1, 0, 1);
    check(28'(off), 28'h002BCDE);
    $display("density test done");
  endtask
  initial begin
    reset_to(1'b1);
    t_write();
    t_refuse();
    t_density();
    results();
  end
endmodule
`default_nettype wire
